/* File: design/osrb_defines.vh */
`ifndef OSRB_DEFINES_VH
`define OSRB_DEFINES_VH
`define OSRB_WIDTH 16
`define OSRB_BIT_SELF_ALIGN 0
`define OSRB_BIT_AUTO_SETUP 2
`define OSRB_BIT_ACTIVE 4
`define OSRB_BIT_WAIT_TRIG 5
`define OSRB_BIT_TRIGGER_OCCURRED 6
`define OSRB_USED_MASK 16'h0075
`define OSRB_SUMMARY_BIT 7
`define OSRB_RISE_PRESET 16'hffff
`define OSRB_FALL_PRESET 16'h0000
`define OSRB_EVENT_RESET 16'h0000
`define OSRB_ENABLE_RESET 16'h0000
`endif

/* File: design/osrb_status_bank.v */
`timescale 1ns/100ps
`include "osrb_defines.vh"
module osrb_status_bank #(
  parameter WIDTH = `OSRB_WIDTH
) (
  input wire mclk,
  input wire rst,
  input wire self_align_running,
  input wire auto_setup_running,
  input wire active_a,
  input wire waiting_for_trigger,
  input wire trigger_occurred,
  input wire preset,
  input wire cond_rd,
  input wire event_rd,
  input wire enable_wr,
  input wire [WIDTH-1:0] enable_wdata,
  input wire rise_wr,
  input wire [WIDTH-1:0] rise_wdata,
  input wire fall_wr,
  input wire [WIDTH-1:0] fall_wdata,
  input wire [6:0] status_byte_other,
  input wire [7:0] service_enable,
  output reg [WIDTH-1:0] rdata_q,
  output reg rvalid_q,
  output reg [WIDTH-1:0] enable_q,
  output reg quest_enable_clear_q,
  output reg [7:0] status_byte_q,
  output reg service_request_q
);
  // Reset and preset values, held at the register width except the 8-bit status byte reset.
  localparam [WIDTH-1:0] ZERO_WORD = {WIDTH{1'b0}};
  localparam [WIDTH-1:0] RISE_PRESET = `OSRB_RISE_PRESET;
  localparam [WIDTH-1:0] FALL_PRESET = `OSRB_FALL_PRESET;
  localparam [WIDTH-1:0] EVENT_RESET = `OSRB_EVENT_RESET;
  localparam [WIDTH-1:0] ENABLE_RESET = `OSRB_ENABLE_RESET;
  localparam [7:0] STATUS_RESET = 8'h00;

  reg [WIDTH-1:0] cond_q;
  reg [WIDTH-1:0] cond_d;
  reg [WIDTH-1:0] prev_q;
  reg [WIDTH-1:0] prev_d;

  reg [WIDTH-1:0] event_q;
  wire [WIDTH-1:0] event_d;
  wire [WIDTH-1:0] hit_w;
  wire [WIDTH-1:0] masked_w;

  reg [WIDTH-1:0] rise_filter_q;
  reg [WIDTH-1:0] rise_filter_d;
  reg [WIDTH-1:0] fall_filter_q;
  reg [WIDTH-1:0] fall_filter_d;
  reg [WIDTH-1:0] enable_d;
  reg quest_enable_clear_d;

  reg [WIDTH-1:0] rdata_d;
  reg rvalid_d;
  reg summary_d;
  reg [7:0] status_byte_d;
  reg service_request_d;
  genvar b;

  // Activities map onto their bit positions.
  // Unused positions stay zero, so a condition read shows them as zero.
  always @* begin
    cond_d = ZERO_WORD;
    cond_d[`OSRB_BIT_SELF_ALIGN] = self_align_running;
    cond_d[`OSRB_BIT_AUTO_SETUP] = auto_setup_running;
    cond_d[`OSRB_BIT_ACTIVE] = active_a;
    cond_d[`OSRB_BIT_WAIT_TRIG] = waiting_for_trigger;
    cond_d[`OSRB_BIT_TRIGGER_OCCURRED] = trigger_occurred;
  end

  // The previous condition word is the reference for edge detection.
  // Both copies reset to zero, so no false edge follows reset.
  always @* begin
    prev_d = cond_q;
  end

  // Each bit compares its condition with the previous one.
  // A permitted transition sets the event bit, and a new event wins over
  // the clear of a coincident read, so no activity is lost to a read; a coincident preset still wins.
  generate
    for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
      wire rise_hit;
      wire fall_hit;
      wire keep_bit;
      assign rise_hit = rise_filter_q[b] & cond_q[b] & ~prev_q[b];
      assign fall_hit = fall_filter_q[b] & ~cond_q[b] & prev_q[b];
      assign hit_w[b] = rise_hit | fall_hit;
      assign keep_bit = event_rd ? 1'b0 : event_q[b];
      assign event_d[b] = preset ? EVENT_RESET[b] : (keep_bit | hit_w[b]);
      assign masked_w[b] = event_d[b] & enable_q[b];
    end
  endgenerate

  // The summary looks at the next event word and the current mask.
  // A mask write therefore shows in the summary one cycle later.
  always @* begin
    summary_d = |masked_w;
  end

  // The summary takes the top bit of the status byte.
  // The lower bits come from the other status sources unchanged.
  always @* begin
    status_byte_d = {summary_d, status_byte_other};
  end

  // A service request is raised while any enabled status bit is set.
  // It is registered together with the status byte it is built from.
  always @* begin
    service_request_d = |(status_byte_d & service_enable);
  end

  // Rising-edge filter next value.
  // Preset wins over a write in the same cycle.
  always @* begin
    rise_filter_d = rise_filter_q;
    if (preset) begin
      rise_filter_d = RISE_PRESET;
    end else if (rise_wr) begin
      rise_filter_d = rise_wdata;
    end
  end

  // Falling-edge filter next value.
  // Preset wins over a write in the same cycle.
  always @* begin
    fall_filter_d = fall_filter_q;
    if (preset) begin
      fall_filter_d = FALL_PRESET;
    end else if (fall_wr) begin
      fall_filter_d = fall_wdata;
    end
  end

  // Enable mask next value.
  // Preset wins over a write in the same cycle.
  // The mask is stored as written; keeping it nonzero is up to the controller.
  always @* begin
    enable_d = enable_q;
    if (preset) begin
      enable_d = ENABLE_RESET;
    end else if (enable_wr) begin
      enable_d = enable_wdata;
    end
  end

  // The questionable bank has its own mask, so preset is passed on as a pulse.
  // It follows the preset by exactly one cycle.
  always @* begin
    quest_enable_clear_d = preset;
  end

  // Read data is valid for exactly one cycle after each read strobe.
  // Outside that cycle the data output rests at zero.
  always @* begin
    rvalid_d = cond_rd | event_rd;
  end

  // An event read returns the word latched before its own clear.
  // An event read wins if both strobes come together.
  // The condition read never disturbs any stored state.
  always @* begin
    if (event_rd) begin
      rdata_d = event_q;
    end else if (cond_rd) begin
      rdata_d = cond_q;
    end else begin
      rdata_d = ZERO_WORD;
    end
  end

  // Condition register.
  // Activity inputs are taken as synchronous to the clock.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cond_q <= ZERO_WORD;
    end else begin
      cond_q <= cond_d;
    end
  end

  // Previous condition register.
  // It lags the condition register by one cycle.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_q <= ZERO_WORD;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Event register.
  // Only a read or a preset clears a bit once it is set.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      event_q <= EVENT_RESET;
    end else begin
      event_q <= event_d;
    end
  end

  // Rising-edge filter register.
  // It leaves reset in its preset state.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rise_filter_q <= RISE_PRESET;
    end else begin
      rise_filter_q <= rise_filter_d;
    end
  end

  // Falling-edge filter register.
  // It leaves reset in its preset state.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fall_filter_q <= FALL_PRESET;
    end else begin
      fall_filter_q <= fall_filter_d;
    end
  end

  // Enable mask register.
  // No event reaches the summary until a mask is written.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable_q <= ENABLE_RESET;
    end else begin
      enable_q <= enable_d;
    end
  end

  // Questionable mask clear pulse.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      quest_enable_clear_q <= 1'b0;
    end else begin
      quest_enable_clear_q <= quest_enable_clear_d;
    end
  end

  // Read data register.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= ZERO_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Read valid register.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // Status byte register.
  // The summary bit is updated on every clock edge.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_byte_q <= STATUS_RESET;
    end else begin
      status_byte_q <= status_byte_d;
    end
  end

  // Service request register.
  // It stands as long as an enabled status bit stays set.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      service_request_q <= 1'b0;
    end else begin
      service_request_q <= service_request_d;
    end
  end

  // Cycle by cycle, an activity change sampled at one edge is detected in
  // the next cycle and is latched, with its summary, at the edge after.
endmodule

/* File: tb/osrb_chk.sv */
`timescale 1ns/100ps
module osrb_chk(
  input wire mclk,
  input wire rst,
  input wire preset,
  input wire cond_rd,
  input wire event_rd,
  input wire enable_wr,
  input wire rvalid_q,
  input wire quest_enable_clear_q,
  input wire service_request_q,
  input wire [6:0] status_byte_other,
  input wire [7:0] service_enable,
  input wire [7:0] status_byte_q,
  input wire [15:0] enable_wdata,
  input wire [15:0] rdata_q,
  input wire [15:0] enable_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_rd_reply: assert property ((cond_rd | event_rd) |=> rvalid_q)
    else $error("no reply");
  chk_rd_idle: assert property (
    !(cond_rd | event_rd) |=> !rvalid_q && rdata_q == 0)
    else $error("idle");
  chk_preset_mask: assert property (
    preset |=> enable_q == 0 && quest_enable_clear_q)
    else $error("preset");
  chk_mask_wr: assert property (
    enable_wr && !preset |=> enable_q == $past(enable_wdata))
    else $error("mask");
  chk_byte_low: assert property (
    1 |=> status_byte_q[6:0] == $past(status_byte_other))
    else $error("byte");
  chk_srq_level: assert property (
    1 |=> service_request_q == |(status_byte_q & $past(service_enable)))
    else $error("srq");
  chk_preset_sum: assert property (preset |=> !status_byte_q[7] [*2])
    else $error("sum");
  chk_mask_zero: assert property (enable_q == 0 |=> !status_byte_q[7])
    else $error("sum0");
  cover property (event_rd ##1 rdata_q != 0);
  cover property (status_byte_q[7]);
  cover property (preset);
  cover property (service_request_q);
endmodule
bind osrb_status_bank osrb_chk i_chk(.*);

/* File: tb/osrb_ctrl_model.sv */
`timescale 1ns/100ps
module osrb_ctrl_model(input wire mclk, input wire go, output reg enable_wr = 0,
  output reg [15:0] enable_wdata = 0);
  always @(posedge mclk) begin
    enable_wr <= go;
    enable_wdata <= 16'($urandom % 65535 + 1);
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`define CHK(n,e,s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb_top;
  reg mclk = 0, rst = 1, preset = 0, cond_rd = 0, event_rd = 0;
  reg rise_wr = 0, fall_wr = 0, go = 0;
  wire srq;
  reg [4:0] act = 0;
  reg [15:0] w = 0;
  wire [15:0] rdata_q, enable_q, enable_wdata;
  wire [7:0] status_byte_q;
  wire enable_wr;
  int error_cnt = 0, n_tests = 0;
  osrb_ctrl_model i_ctrl(.mclk(mclk), .go(go), .enable_wr(enable_wr),
    .enable_wdata(enable_wdata));
  osrb_status_bank i_dut(.self_align_running(act[0]), .auto_setup_running(act[1]),
    .active_a(act[2]), .waiting_for_trigger(act[3]), .trigger_occurred(act[4]),
    .rise_wdata(16'h0000), .fall_wdata(16'hffff), .status_byte_other({act, act[1:0]}),
    .service_enable({act, 3'h5}), .rvalid_q(), .quest_enable_clear_q(),
    .service_request_q(srq), .*);
  task rd(input bit e, input logic [15:0] x);
    @(posedge mclk) {event_rd, cond_rd} <= {e, !e};
    @(posedge mclk) {event_rd, cond_rd} <= 0;
    #1 `CHK("rdata", x, rdata_q)
  endtask
  task report_and_stop;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #4 mclk = ~mclk;
  initial begin
    #40000 error_cnt++;
    report_and_stop;
  end
  initial begin
    w = $urandom(32'h6456bacd);
    repeat (6) @(posedge mclk);
    rst <= 0;
    w = $urandom % 31 + 1;
    act <= w[4:0];
    repeat (3) @(posedge mclk);
    rd(0, {w[4:2], 1'b0, w[1], 1'b0, w[0]});
    rd(0, {w[4:2], 1'b0, w[1], 1'b0, w[0]});
    rd(1, {w[4:2], 1'b0, w[1], 1'b0, w[0]});
    rd(1, 16'h0000);
    @(posedge mclk) {preset, rise_wr, fall_wr} <= 3'b111;
    @(posedge mclk) {preset, rise_wr, fall_wr} <= 0;
    act <= 0;
    repeat (3) @(posedge mclk);
    rd(1, 16'h0000);
    act <= w[4:0];
    repeat (3) @(posedge mclk);
    rd(1, {w[4:2], 1'b0, w[1], 1'b0, w[0]});
    go <= 1;
    @(posedge mclk) go <= 0;
    #1 w = enable_wdata;
    @(posedge mclk) #1 `CHK("mask", w, enable_q)
    act <= 0;
    repeat (3) @(posedge mclk) act <= 5'h1f;
    #1 `CHK("summary", |(16'h0075 & w), status_byte_q[7])
    `CHK("srq", 1'b1, srq)
    @(posedge mclk) preset <= 1;
    @(posedge mclk) preset <= 0;
    #1 `CHK("mask0", 16'h0000, enable_q)
    rd(1, 16'h0000);
    report_and_stop;
  end
endmodule
